// *** flash_status_consts.svh ***
// Purpose: constants for the flash status/protection block
// Assumes: 100 MHz i_clk, SPI mode 0/3 framing, MSB first
// Notes: bit positions, opcodes and reset values
// Summary of operation
// - busy flag high during program, erase, write
// - write latch low rejects writes, programs, erases
// - block protect bits change only by status write
// - refuse program/erase inside protected area; program is checked at sh[39:16] (opcode and address 23..8)
// - chip erase only when fully unprotected
// - complement bit inverts the protected range
// - complement bit at 14, default zero
// - lock high bit zero: writable when latch set
// - lock (1,0) refuses writes until power cycle
// - lock (1,1) refuses status writes until power cycle
// - quad enable read-only, always one
// - security locks 13..11 set once, cleared only by power cycle
// - set security lock makes register read-only
// - suspend sets erase or program suspended bit
// - resume or power cycle clears suspend bits
// - complement zero selects range directly
// - write latch set/cleared by listed commands
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
`define BIT_BUSY 0
`define BIT_WEL 1
`define BIT_BP_LO 2
`define BIT_LOCK_LO 7
`define BIT_LOCK_HI 8
`define BIT_QE 9
`define BIT_PSUS 10
`define BIT_SEC_LO 11
`define BIT_CMP 14
`define BIT_ESUS 15
`define STATUS_RESET 16'h0200
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_RDSR0 8'h05
`define OP_RDSR1 8'h35
`define OP_STATUS_WRITE_CMD 8'h01
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_CE1 8'hC7
`define OP_CE2 8'h60
`define OP_SUSP 8'h75
`define OP_RESUME 8'h7A
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_ERSEC 8'h44
`define OP_PRSEC 8'h42
`define WRITE_TIME_NS 1000
`define WRITE_CYCLES ((`WRITE_TIME_NS + 9) / 10)
`endif

// *** flash_status_pkg.sv ***
package flash_status_pkg;
    typedef struct packed {
        logic erase_suspended;
        logic protect_complement;
        logic [2:0] security_lock;
        logic program_suspended;
        logic quad_pins_on;
        logic status_lock_hi;
        logic status_lock_lo;
        logic [4:0] block_protect;
        logic write_latch_flag;
        logic busy_flag;
    } status_s;
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_BUSY = 2'b01
    } op_state_e;
endpackage : flash_status_pkg

// *** protect_decode.sv ***
// Purpose: decide whether an address lies in the protected area
// Assumes: 24-bit address, 16 MB array
// Notes: purely combinational
`timescale 1ns/1ns
`include "flash_status_consts.svh"
module protect_decode (
    // protection code
    input wire logic [4:0] i_bp,
    input wire logic i_cmp,
    // query
    input wire logic [23:0] i_addr,
    output logic o_protected
);
    wire [2:0] size = i_bp[2:0];
    wire small_blk = i_bp[4];
    wire lower = i_bp[3];
    // number of low-order address bits spanned by the range
    // small blocks saturate at 32 KB for codes 10x and 110
    wire [4:0] sh = small_blk ? 5'd11 + {2'b00, (size[2] ? 3'd4 : size)}
                              : 5'd17 + {2'b00, size};
    wire [23:0] lim = 24'h00_0001 << sh;
    wire in_low = i_addr < lim;
    wire in_high = i_addr >= (24'h00_0000 - lim);
    wire none = (size == 3'b000);
    wire all = (size == 3'b111) ||
               (!small_blk && size == 3'b111);
    wire raw = none ? 1'b0 : all ? 1'b1 : (lower ? in_low : in_high);
    assign o_protected = i_cmp ? ~raw : raw;
endmodule : protect_decode

// *** flash_status_core.sv ***
// Purpose: status register, write latch and array protection of the flash
// Assumes: SPI pins sampled by i_clk through two flip-flops
// Notes: array and security datapaths stay outside; only verdicts leave
`timescale 1ns/1ns
`include "flash_status_consts.svh"
module flash_status_core
    import flash_status_pkg::*;
#(
    parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // spi pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // operation status from array engine
    input wire logic i_suspend_is_erase,
    // decisions
    output logic o_array_start,
    output logic [7:0] o_array_op,
    output logic [23:0] o_array_addr,
    output logic [2:0] o_secreg_readonly,
    output logic [15:0] o_status
);
    // busy counter is 16 bits wide
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin : g_bad_cycles
        $error("WRITE_CYCLES out of range");
    end
    // ==========================================================
    // pin synchronisers
    logic [2:0] s1, s2;
    logic sclk_d;
    always_ff @(posedge i_clk) begin
        s1 <= {i_sclk, i_cs_n, i_si};
        s2 <= s1;
        sclk_d <= s2[2];
    end
    wire cs_n = s2[1];
    wire si = s2[0];
    wire rise = s2[2] & ~sclk_d;
    wire fall = ~s2[2] & sclk_d;
    // ==========================================================
    // shifter
    logic [5:0] nbits;
    logic [39:0] sh;
    logic cs_d;
    logic [7:0] op;
    logic rst_armed;
    always_ff @(posedge i_clk) begin
        cs_d <= cs_n;
        if (i_reset || cs_n) begin
            nbits <= '0;
        end else if (rise) begin
            sh <= {sh[38:0], si};
            if (nbits != 6'd63) nbits <= nbits + 6'd1;
            if (nbits == 6'd7) op <= {sh[6:0], si};
        end
    end
    wire frame_end = cs_n & ~cs_d;
    wire aligned = (nbits[2:0] == 3'd0);
    wire [7:0] cmd = sh[7:0];
    // ==========================================================
    // status register
    status_s st;
    logic [15:0] busy_cnt;
    wire prot;
    wire [23:0] addr = sh[23:0];
    protect_decode u_dec (
        .i_bp(st.block_protect),
        .i_cmp(st.protect_complement),
        .i_addr(addr),
        .o_protected(prot)
    );
    wire one_byte = frame_end && aligned && nbits == 6'd8;
    wire four_byte = frame_end && aligned && nbits == 6'd32;
    wire pp_end = frame_end && aligned && nbits >= 6'd40 &&
                  (op == `OP_PP || op == `OP_QPP);
    wire idle = !st.busy_flag;
    wire may_write = idle && st.write_latch_flag;
    wire is_erase = (op == `OP_SE || op == `OP_BE32 || op == `OP_BE64);
    wire [23:0] pp_addr = sh[39:16];
    logic pp_prot;
    protect_decode u_dec_pp (
        .i_bp(st.block_protect),
        .i_cmp(st.protect_complement),
        .i_addr(pp_addr),
        .o_protected(pp_prot)
    );
    wire status_write_cmd_end = frame_end && aligned && op == `OP_STATUS_WRITE_CMD &&
                    (nbits == 6'd16 || nbits == 6'd24);
    wire lock_free = !st.status_lock_hi;
    wire do_status_write_cmd = status_write_cmd_end && may_write && lock_free;
    wire [15:0] wv = (nbits == 6'd24) ? {sh[7:0], sh[15:8]}
                                      : {o_status[15:8], sh[7:0]};
    wire ce_ok = (st.block_protect[2:0] == 3'b000 && !st.protect_complement) ||
                 (st.block_protect[2:0] == 3'b111 && st.protect_complement);
    wire do_ce = one_byte && may_write && ce_ok &&
                 (cmd == `OP_CE1 || cmd == `OP_CE2);
    wire do_er = four_byte && may_write && is_erase && !prot;
    wire do_pp = pp_end && may_write && !pp_prot;
    wire sec_pe = frame_end && aligned && may_write &&
                  (op == `OP_ERSEC || op == `OP_PRSEC);
    wire sw_reset = one_byte && rst_armed && cmd == `OP_RST;
    wire start = do_ce || do_er || do_pp || do_status_write_cmd;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st <= `STATUS_RESET;
            busy_cnt <= '0;
            rst_armed <= 1'b0;
        end else begin
            if (one_byte) rst_armed <= (cmd == `OP_RSTEN);
            if (start) begin
                st.busy_flag <= 1'b1;
                busy_cnt <= 16'(WRITE_CYCLES);
            end else if (busy_cnt != 16'h0000) begin
                busy_cnt <= busy_cnt - 16'h0001;
                if (busy_cnt == 16'h0001) st.busy_flag <= 1'b0;
            end
            if (one_byte && idle && cmd == `OP_WRITE_ENABLE_CMD)
                st.write_latch_flag <= 1'b1;
            if ((one_byte && cmd == `OP_WRITE_DISABLE_CMD) || start || sec_pe || sw_reset)
                st.write_latch_flag <= 1'b0;
            if (do_status_write_cmd) begin
                st.block_protect <= wv[6:2];
                st.status_lock_lo <= wv[7];
                st.status_lock_hi <= wv[8];
                st.security_lock <= st.security_lock | wv[13:11];
                st.protect_complement <= wv[14];
            end
            if (one_byte && cmd == `OP_SUSP && st.busy_flag) begin
                if (i_suspend_is_erase) st.erase_suspended <= 1'b1;
                else st.program_suspended <= 1'b1;
                st.busy_flag <= 1'b0;
            end
            if (one_byte && cmd == `OP_RESUME) begin
                st.erase_suspended <= 1'b0;
                st.program_suspended <= 1'b0;
            end
            st.quad_pins_on <= 1'b1;
        end
    end
    // ==========================================================
    // read-back and outputs
    logic [7:0] rd_byte;
    always_ff @(posedge i_clk) begin
        if (i_reset || cs_n) begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            rd_byte <= '0;
        end else if (fall && nbits >= 6'd8 && nbits[2:0] == 3'd0) begin
            rd_byte <= (op == `OP_RDSR1) ? st[15:8] : st[7:0];
            o_so <= (op == `OP_RDSR1) ? st[15] : st[7];
            o_so_oe <= (op == `OP_RDSR0 || op == `OP_RDSR1);
        end else if (fall && nbits > 6'd8) begin
            o_so <= rd_byte[7 - nbits[2:0]];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_array_start <= 1'b0;
            o_array_op <= '0;
            o_array_addr <= '0;
            o_status <= `STATUS_RESET;
            o_secreg_readonly <= '0;
        end else begin
            o_array_start <= do_ce || do_er || do_pp;
            if (start) o_array_op <= do_ce ? cmd : op;
            if (do_er) o_array_addr <= addr;
            if (do_pp) o_array_addr <= pp_addr;
            o_status <= st;
            o_secreg_readonly <= st.security_lock;
        end
    end
endmodule : flash_status_core

// *** flash_status_sva.sv ***
// Purpose: port checks for flash_status_core
// Assumes: i_reset models a power cycle
// Notes: bound below
`timescale 1ns/1ns
`include "flash_status_consts.svh"
module flash_status_sva #(
    parameter int WRITE_CYCLES = 100
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // spi pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic o_so,
    input wire logic o_so_oe,
    // engine and verdicts
    input wire logic i_suspend_is_erase,
    input wire logic o_array_start,
    input wire logic [7:0] o_array_op,
    input wire logic [23:0] o_array_addr,
    input wire logic [2:0] o_secreg_readonly,
    input wire logic [15:0] o_status
);
    // ====================
    // busy run length
    int busy_run;
    always_ff @(posedge i_clk) begin
        busy_run <= (i_reset || !o_status[0]) ? 0 : busy_run + 1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence busy_held;
        o_status[0] [*3];
    endsequence
    qe_fixed_a: assert property (o_status[9])
        else $error("quad bit low");
    ro_follow_a: assert property (o_secreg_readonly == o_status[13:11])
        else $error("readonly differs");
    sec_sticky_a: assert property ($past(o_status[13:11])
        == (o_status[13:11] & $past(o_status[13:11]))) else $error("lock lost");
    start_wel_a: assert property (o_array_start |-> $past(o_status[1]))
        else $error("start without latch");
    start_busy_a: assert property (o_array_start |=> busy_held)
        else $error("busy missing");
    busy_len_a: assert property (busy_run <= WRITE_CYCLES + 2)
        else $error("busy too long");
    ce_gate_a: assert property (o_array_start && (o_array_op == `OP_CE1
        || o_array_op == `OP_CE2) |-> o_status[4:2] == {3{o_status[14]}})
        else $error("chip erase allowed");
    bp_write_a: assert property ($changed({o_status[14], o_status[6:2]})
        |-> $past(o_status[1]) || $past(o_status[0])) else $error("bp changed");
endmodule : flash_status_sva
bind flash_status_core flash_status_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe),
    .i_suspend_is_erase(i_suspend_is_erase), .o_array_start(o_array_start),
    .o_array_op(o_array_op), .o_array_addr(o_array_addr),
    .o_secreg_readonly(o_secreg_readonly), .o_status(o_status));

// *** spi_host.sv ***
// Purpose: spi mode 0 host model
// Assumes: 160 ns link clock, idle low
// Notes: si shows inverse of last bit when deselected
`timescale 1ns/1ns
module spi_host (
    // spi pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    // ====================
    // frame transfer, msb first
    initial begin
        o_sclk = 0;
        o_cs_n = 1;
        o_si = 0;
    end
    task automatic send(input logic [31:0] d, input int n, output logic [7:0] rx);
        o_cs_n = 0;
        for (int i = 0; i < 8 * n; i++) begin
            o_si = d[31 - i];
            #80 o_sclk = 1;
            rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
            #80 o_sclk = 0;
        end
        o_cs_n = 1;
        o_si = ~o_si;
    endtask : send
endmodule : spi_host

// *** tb_top.sv ***
// Purpose: self-checking bench for flash_status_core
// Assumes: seed 77302, busy lengthened to 400 cycles
// Notes: host model drives the spi pins
`timescale 1ns/1ns
`include "flash_status_consts.svh"
module tb_top;
    // ====================
    // bench and design
    logic i_clk, i_reset, sclk, cs_n, si, so, so_oe, i_suspend_is_erase, start;
    logic [7:0] op, rx;
    logic [23:0] addr;
    logic [2:0] ro;
    logic [15:0] st;
    int bad_count, checks_done, starts;
    logic [29:0] cor [4] = '{{5'h01, 1'b0, 24'hFC_0000},
        {5'h01, 1'b0, 24'hFB_FFFF}, {5'h09, 1'b1, 24'h04_0000},
        {5'h09, 1'b1, 24'h03_FFFF}};
    logic [7:0] ops [3] = '{`OP_SE, `OP_BE32, `OP_BE64};
    flash_status_core #(.WRITE_CYCLES(400)) i_flash_status_core (
        .i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .i_suspend_is_erase(i_suspend_is_erase), .o_array_start(start),
        .o_array_op(op), .o_array_addr(addr), .o_secreg_readonly(ro),
        .o_status(st));
    spi_host i_spi_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
        .i_so(so), .i_so_oe(so_oe));
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (start === 1'b1) starts++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic cmd(input logic [31:0] d, input int n);
        @(posedge i_clk);
        #1 i_spi_host.send(d, n, rx);
        repeat (8) @(posedge i_clk);
    endtask : cmd
    task automatic idle;
        for (int i = 0; i < 1000 && st[0] !== 1'b0; i++) @(posedge i_clk);
        chk(st[0], 1'b0);
    endtask : idle
    task automatic status_write_cmd(input logic [15:0] v);
        cmd({`OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1);
        cmd({`OP_STATUS_WRITE_CMD, v[7:0], v[15:8], 8'h00}, 3);
        idle;
    endtask : status_write_cmd
    task automatic do_reset;
        #1 i_reset = 1;
        repeat (20) @(posedge i_clk);
        #1 i_reset = 0;
        repeat (4) @(posedge i_clk);
    endtask : do_reset
    // expected protection verdict
    function automatic bit prot(logic [4:0] b, logic c, logic [23:0] a);
        int s;
        bit p;
        p = b[2:0] == 3'h7;
        s = b[4] ? 32'h0000_1000 << (b[2:0] > 3 ? 3 : b[2:0] - 1)
            : 32'h0004_0000 << (b[2:0] - 1);
        if (b[2:0] != 0 && !p) p = b[3] ? a < s : a >= 32'h0100_0000 - s;
        return p ^ c;
    endfunction : prot
    initial begin
        logic [4:0] b;
        logic c;
        logic [23:0] a;
        logic [31:0] r;
        int n0;
        i_suspend_is_erase = 0;
        r = $urandom(77302);
        do_reset;
        chk(st, 16'h0200);
        cmd({`OP_STATUS_WRITE_CMD, 8'h04, 8'h02, 8'h00}, 3);
        chk(st, 16'h0200);
        for (int t = 0; t < 12; t++) begin
            r = $urandom;
            {b, c, a} = t < 4 ? cor[t] : r[29:0];
            status_write_cmd({1'b0, c, 7'h04, b, 2'h0});
            chk(st, {1'b0, c, 7'h04, b, 2'h0});
            cmd({`OP_RDSR0, 24'h00_0000}, 2);
            chk(rx, {1'b0, b, 2'h0});
            n0 = starts;
            cmd({`OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1);
            cmd({ops[t % 3], a}, 4);
            idle;
            chk(starts - n0, !prot(b, c, a));
            if (starts != n0) chk(addr, a);
            if (starts != n0) chk(op, ops[t % 3]);
            n0 = starts;
            cmd({`OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1);
            cmd({`OP_CE2, 24'h00_0000}, 1);
            idle;
            chk(starts - n0, b[2:0] == {3{c}});
        end
        status_write_cmd(16'h0A00);
        status_write_cmd(16'h0200);
        chk(st, 16'h0A00);
        chk(ro, 3'h1);
        #1 i_suspend_is_erase = 1;
        cmd({`OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1);
        cmd({`OP_SE, 24'h00_0000}, 4);
        cmd({`OP_SUSP, 24'h00_0000}, 1);
        chk(st & 16'h8401, 16'h8000);
        cmd({`OP_RESUME, 24'h00_0000}, 1);
        chk(st[15], 1'b0);
        idle;
        status_write_cmd(16'h0300);
        status_write_cmd(16'h0204);
        chk(st, 16'h0B02);
        do_reset;
        chk(st, 16'h0200);
        status_write_cmd(16'h0380);
        status_write_cmd(16'h0204);
        chk(st, 16'h0382);
        report_and_stop;
    end
    initial begin
        #900_000;
        bad_count++;
        report_and_stop;
    end
endmodule : tb_top
